// ===== fir_decim_top.sv
// Purpose: decimating symmetric fir filter for one adc channel
// Assumes: samples and out_ready come from logic on ref_clk
// Notes: apb slave answers with one wait state
// Summary of operation
// - configuration picks rate, band, coefficient source
// - rate 001/000, choice 000, odd: low-pass
// - rate 001/000, choice 001, odd: high-pass
// - rate 010/001, choice 010, even: low-pass
// - decimate-4, choice 011, even: first band-pass
// - decimate-4, choice 100, even: second band-pass
// - decimate-4, choice 101, odd: high-pass
// - custom coefficients at any rate or bypass
// - default 24 symmetric taps, 12-bit signed
// - odd length select gives 23 taps
// - built-in responses use internal fixed sets
// - coefficient equals real value times 2^11
`timescale 1ns/1ps
module fir_decim_top (
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    input  wire logic [fir_pkg::APB_AW-1:0] paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [fir_pkg::SAMPLE_W-1:0] sample_in,
    input  wire logic                       sample_valid,
    output logic                            sample_ready,
    output logic      [fir_pkg::SAMPLE_W-1:0] out_data,
    output logic                            out_valid,
    input  wire logic                       out_ready
);
    import fir_pkg::*;

    logic                 rst_ff1_q;
    logic                 rst_sync_n;
    logic [CTRL_W-1:0]    ctrl_q;
    coef_set_t            user_coef_q;
    coef_set_t            rom_coef;
    coef_set_t            act_coef;
    logic [SAMPLE_W-1:0]  x_q [FULL_TAPS];
    logic [2:0]           dec_cnt_q;
    logic [2:0]           dec_cnt_d;
    logic                 pend_q;
    logic                 pend_d;
    logic [15:0]          out_cnt_q;
    logic [2:0]           gap_q;

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_ff1_q  <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_ff1_q  <= 1'b1;
            rst_sync_n <= rst_ff1_q;
        end
    end

    // apb decode
    wire        access    = psel & penable;
    wire        first_acc = access & ~pready;
    wire        wr_en     = access & pready & pwrite;
    wire        ctrl_hit  = paddr == ADDR_CTRL;
    wire        stat_hit  = paddr == ADDR_STATUS;
    wire        ocnt_hit  = paddr == ADDR_OUTCNT;
    wire        coef_hit  = paddr >= ADDR_COEF0 && paddr <= ADDR_COEF11
                            && paddr[1:0] == 2'h0;
    wire        addr_hit  = ctrl_hit | stat_hit | ocnt_hit | coef_hit;
    wire [7:0]  coef_off  = paddr - ADDR_COEF0;
    wire [3:0]  coef_idx  = coef_off[5:2];
    wire        ctrl_wr   = wr_en & ctrl_hit;

    // configuration fields
    wire [2:0]  rate_sel  = ctrl_q[F_RATE +: 3];
    wire [2:0]  fdec_sel  = ctrl_q[F_FDEC +: 3];
    wire [2:0]  choice    = ctrl_q[F_CHOICE +: 3];
    wire        odd_sel   = ctrl_q[F_ODD];
    wire        chan_en   = ctrl_q[F_CHAN_EN];
    wire        cust_en   = ctrl_q[F_CUST_EN];
    wire        src_sel   = ctrl_q[F_SRC_SEL];

    // rate decode; other codes bypass decimation
    wire        is_dec2   = rate_sel == RATE_DEC2;
    wire        is_dec4   = rate_sel == RATE_DEC4;
    wire        is_dec8   = rate_sel == RATE_DEC8;
    wire [2:0]  factor_m1 = is_dec8 ? 3'h7 :
                            is_dec4 ? 3'h3 :
                            is_dec2 ? 3'h1 : 3'h0;
    wire        rate_pair = (is_dec2 && fdec_sel == FDEC_DEC2)
                          | (is_dec4 && fdec_sel == FDEC_DEC4)
                          | (is_dec8 && fdec_sel == FDEC_DEC8);
    wire        bypass    = !(is_dec2 | is_dec4 | is_dec8);
    wire        use_cust  = chan_en & cust_en & src_sel
                          & (choice == 3'h0);
    wire        ok_dec2   = is_dec2 & odd_sel
                          & (choice == 3'(CH_LP_ODD)
                           | choice == 3'(CH_HP_ODD));
    wire        ok_dec4   = is_dec4 & (odd_sel ?
                            choice == 3'(CH_HP4_ODD) :
                            (choice == 3'(CH_LP_EVEN)
                           | choice == 3'(CH_BP1_EVEN)
                           | choice == 3'(CH_BP2_EVEN)));
    wire        cfg_ok    = !chan_en
                          | (use_cust & (rate_pair | bypass))
                          | (!cust_en & rate_pair & (ok_dec2 | ok_dec4));

    fir_coef_rom u_rom (
        .choice (choice),
        .coef   (rom_coef)
    );

    assign act_coef = use_cust ? user_coef_q : rom_coef;

    // stream handshake
    wire        acc       = sample_valid & sample_ready;
    wire        last_in   = !chan_en || dec_cnt_q >= factor_m1;
    wire        produce   = acc & last_in;

    fir_stream_if #(.W(SAMPLE_W)) res_s ();

    wire        push      = pend_q & res_s.ready;

    assign dec_cnt_d = produce ? 3'h0 : dec_cnt_q + 3'h1;
    assign pend_d    = (pend_q & ~push) | produce;

    // sample delay line, newest in slot 0
    for (genvar i = 0; i < FULL_TAPS; i++) begin : g_dly
        always_ff @(posedge ref_clk or negedge rst_sync_n)
        begin
            if (!rst_sync_n)
                x_q[i] <= '0;
            else if (acc)
                x_q[i] <= (i == 0) ? sample_in : x_q[(i == 0) ? 0 : i-1];
        end
    end

    // symmetric pre-add and multiply
    logic signed [12:0] pair_sum [HALF_TAPS];
    logic signed [24:0] prod     [HALF_TAPS];

    for (genvar k = 0; k < HALF_TAPS; k++) begin : g_mac
        wire signed [12:0] near = 13'($signed(x_q[k]));
        wire signed [12:0] far_e = 13'($signed(x_q[FULL_TAPS-1-k]));
        wire signed [12:0] far_o = (k == HALF_TAPS - 1) ? 13'h0000 :
                                   13'($signed(x_q[FULL_TAPS-2-k]));
        // odd form drops the last sample and keeps h11 single
        assign pair_sum[k] = near + (odd_sel ? far_o : far_e);
        assign prod[k] = 25'(pair_sum[k])
                       * 25'($signed(act_coef[k]));
    end

    logic signed [28:0] acc_sum;
    logic signed [28:0] scaled;
    logic [SAMPLE_W-1:0] fir_y;

    always_comb
    begin
        acc_sum = '0;
        for (int k = 0; k < HALF_TAPS; k++)
            acc_sum = acc_sum + 29'(prod[k]);
    end

    // coefficients carry eleven fraction bits
    assign scaled = acc_sum >>> COEF_FRAC;
    wire   sat_hi = scaled > 29'sd2047;
    wire   sat_lo = scaled < -29'sd2048;
    assign fir_y  = sat_hi ? 12'h7ff :
                    sat_lo ? 12'h800 : scaled[SAMPLE_W-1:0];

    assign res_s.data  = chan_en ? fir_y : x_q[0];
    assign res_s.valid = pend_q;

    fir_out_buffer #(.W(SAMPLE_W), .DEPTH(2)) u_buf (
        .clk       (ref_clk),
        .rst_n     (rst_sync_n),
        .in        (res_s),
        .out_data  (out_data),
        .out_valid (out_valid),
        .out_ready (out_ready)
    );

    // filter sequencing
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            dec_cnt_q    <= '0;
            pend_q       <= 1'b0;
            sample_ready <= 1'b0;
            out_cnt_q    <= '0;
        end
        else
        begin
            if (ctrl_wr)
                dec_cnt_q <= '0;
            else if (acc)
                dec_cnt_q <= dec_cnt_d;
            pend_q       <= pend_d;
            sample_ready <= ~pend_d;
            if (push)
                out_cnt_q <= out_cnt_q + 16'h0001;
        end
    end

    // register writes
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            ctrl_q <= CTRL_RESET;
        else if (ctrl_wr)
            ctrl_q <= pwdata[CTRL_W-1:0];
    end

    for (genvar i = 0; i < HALF_TAPS; i++) begin : g_ucoef
        always_ff @(posedge ref_clk or negedge rst_sync_n)
        begin
            if (!rst_sync_n)
                user_coef_q[i] <= COEF_RESET;
            else if (wr_en && coef_hit && coef_idx == 4'(i))
                user_coef_q[i] <= pwdata[COEF_W-1:0];
        end
    end

    // read mux
    wire [31:0] stat_word = {24'h0, 1'b0, factor_m1, 1'b0, bypass,
                             cfg_ok, pend_q};
    wire [31:0] rd_word   = ctrl_hit ? {19'h0, ctrl_q} :
                            stat_hit ? stat_word :
                            ocnt_hit ? {16'h0, out_cnt_q} :
                            coef_hit ? {20'h0, user_coef_q[coef_idx]} :
                            32'h0;

    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else
        begin
            pready  <= first_acc;
            pslverr <= first_acc & ~addr_hit;
            if (first_acc)
                prdata <= pwrite ? 32'h0 : rd_word;
        end
    end

    // accepted samples since last output, checks only
    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            gap_q <= '0;
        else if (ctrl_wr || produce)
            gap_q <= '0;
        else if (acc)
            gap_q <= gap_q + 3'h1;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_sync_n);

    a_decim_ratio_count: assert property (
        produce && chan_en && !ctrl_wr |-> gap_q == factor_m1)
        else $error("output not after N accepted samples");

    a_ready_drops_out: assert property (
        produce |=> !sample_ready ##0 res_s.valid)
        else $error("produced word not pending");

    a_pend_hold_stall: assert property (
        pend_q && !res_s.ready |=> pend_q && $stable(x_q[0]))
        else $error("pending word lost while stalled");

    a_custom_path_sel: assert property (
        use_cust |-> act_coef == user_coef_q)
        else $error("custom coefficients not in use");

    a_builtin_path_sel: assert property (
        chan_en && !use_cust |-> act_coef == rom_coef)
        else $error("built-in set not in use");

    a_odd_centre_tap: assert property (
        odd_sel |-> pair_sum[11] == 13'($signed(x_q[11])))
        else $error("centre tap not single");

    a_even_outer_pair: assert property (
        !odd_sel |-> pair_sum[0] ==
        13'($signed(x_q[0])) + 13'($signed(x_q[23])))
        else $error("outer pair wrong in 24-tap form");

    a_odd_outer_pair: assert property (
        odd_sel |-> pair_sum[0] ==
        13'($signed(x_q[0])) + 13'($signed(x_q[22])))
        else $error("outer pair wrong in 23-tap form");

    a_apb_wait_state: assert property (
        access && !pready |=> pready ##1 !pready)
        else $error("apb answer not one wait state");

    a_ctrl_write_take: assert property (
        ctrl_wr |=> ctrl_q == $past(pwdata[CTRL_W-1:0]))
        else $error("ctrl write not taken");

    a_out_hold_stall: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("output word changed while stalled");

    a_dec_phase_restart: assert property (
        ctrl_wr |=> dec_cnt_q == 3'h0)
        else $error("decimation phase not restarted");

    c_bypass_custom: cover property (produce && bypass && use_cust);
    c_dec2_out: cover property (produce && chan_en && is_dec2);
    c_dec4_out: cover property (produce && chan_en && is_dec4);
    c_dec8_custom: cover property (produce && is_dec8 && use_cust);
    c_buffer_stall: cover property (pend_q && !res_s.ready);
endmodule : fir_decim_top

// ===== fir_pkg.sv
// Purpose: shared constants for the decimating fir filter
// Assumes: apb with 32-bit data, one register per aligned word
// Notes: coefficients are 12-bit two's complement, scaled by 2^11
package fir_pkg;
    localparam int SAMPLE_W    = 12;
    localparam int COEF_W      = 12;
    localparam int HALF_TAPS   = 12;
    localparam int FULL_TAPS   = 24;
    localparam int COEF_FRAC   = 11;
    localparam int APB_AW      = 8;
    localparam int CTRL_W      = 13;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_OUTCNT = 8'h08;
    localparam logic [7:0] ADDR_COEF0  = 8'h10;
    localparam logic [7:0] ADDR_COEF11 = 8'h3c;

    // ctrl field positions
    localparam int F_RATE     = 0;
    localparam int F_FDEC     = 3;
    localparam int F_CHOICE   = 6;
    localparam int F_ODD      = 9;
    localparam int F_CHAN_EN  = 10;
    localparam int F_CUST_EN  = 11;
    localparam int F_SRC_SEL  = 12;

    localparam logic [12:0] CTRL_RESET = 13'h0000;
    localparam logic [11:0] COEF_RESET = 12'h000;

    localparam logic [2:0] RATE_DEC2 = 3'h1;
    localparam logic [2:0] RATE_DEC4 = 3'h2;
    localparam logic [2:0] RATE_DEC8 = 3'h3;
    localparam logic [2:0] FDEC_DEC2 = 3'h0;
    localparam logic [2:0] FDEC_DEC4 = 3'h1;
    localparam logic [2:0] FDEC_DEC8 = 3'h4;

    typedef enum logic [2:0] {
        CH_LP_ODD, CH_HP_ODD, CH_LP_EVEN, CH_BP1_EVEN, CH_BP2_EVEN, CH_HP4_ODD
    } choice_e;

    typedef logic [HALF_TAPS-1:0][COEF_W-1:0] coef_set_t;
endpackage : fir_pkg

// ===== fir_stream_if.sv
// Purpose: valid/ready word stream between filter core and buffer
// Assumes: one clock, word taken when valid and ready are both high
// Notes: none
`timescale 1ns/1ps
interface fir_stream_if #(parameter int W = 12);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : fir_stream_if

// ===== fir_out_buffer.sv
// Purpose: shifting output buffer, head entry drives the outputs
// Assumes: in.ready and out_valid come straight from flops
// Notes: default depth of two covers one stall cycle of the drain
`timescale 1ns/1ps
module fir_out_buffer #(
    parameter int W     = 12,
    parameter int DEPTH = 2
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    fir_stream_if.snk         in,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int CW = $clog2(DEPTH + 1);
    logic [W-1:0]  mem_q [DEPTH];
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [CW-1:0] fill_at;
    logic          rdy_q;
    logic          push;
    logic          pop;

    assign push     = in.valid & rdy_q;
    assign pop      = out_valid & out_ready;
    assign fill_at  = pop ? cnt_q - CW'(1) : cnt_q;
    assign cnt_d    = cnt_q + CW'(push) - CW'(pop);
    assign in.ready = rdy_q;
    assign out_data = mem_q[0];

    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        logic [W-1:0] nxt;
        if (i == DEPTH - 1) begin : g_last
            assign nxt = mem_q[i];
        end
        else begin : g_mid
            assign nxt = mem_q[i+1];
        end
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                mem_q[i] <= '0;
            else if (push && fill_at == CW'(i))
                mem_q[i] <= in.data;
            else if (pop)
                mem_q[i] <= nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q     <= '0;
            rdy_q     <= 1'b0;
            out_valid <= 1'b0;
        end
        else
        begin
            cnt_q     <= cnt_d;
            rdy_q     <= cnt_d != CW'(DEPTH);
            out_valid <= cnt_d != '0;
        end
    end
endmodule : fir_out_buffer

// ===== fir_coef_rom.sv
// Purpose: fixed coefficient sets for the built-in responses
// Assumes: h0 is the outer tap, h11 the centre side
// Notes: shapes come from one low-pass prototype by modulation
`timescale 1ns/1ps
module fir_coef_rom (
    input  wire logic [2:0]         choice,
    output fir_pkg::coef_set_t      coef
);
    import fir_pkg::*;
    localparam coef_set_t BASE = {
        12'h1a4, 12'h14a, 12'h0a0, 12'h000, 12'hfba, 12'hfd3,
        12'h000, 12'h016, 12'h00e, 12'h000, 12'hffa, 12'hffd
    };

    for (genvar k = 0; k < HALF_TAPS; k++) begin : g_tap
        logic [COEF_W-1:0] b;
        logic [COEF_W-1:0] nb;
        logic [COEF_W-1:0] alt;
        assign b   = BASE[k];
        assign nb  = COEF_W'(-b);
        assign alt = (k % 2 == 1) ? nb : b;
        always_comb
        begin
            case (choice)
                3'(CH_LP_ODD):   coef[k] = b;
                3'(CH_HP_ODD):   coef[k] = alt;
                3'(CH_LP_EVEN):  coef[k] = b;
                3'(CH_BP1_EVEN): coef[k] = (k % 4 == 0) ? b :
                                           (k % 4 == 2) ? nb : '0;
                3'(CH_BP2_EVEN): coef[k] = (k % 4 == 1) ? b :
                                           (k % 4 == 3) ? nb : '0;
                3'(CH_HP4_ODD):  coef[k] = alt;
                default:         coef[k] = b;
            endcase
        end
    end
endmodule : fir_coef_rom

// ===== fir_decim_top_test.sv
// Purpose: self-checking bench for the decimating fir filter
// Assumes: apb answers with pready, samples and outputs use valid/ready
// Notes: words produced before the tap line is full of known samples are skipped
`timescale 1ns/1ps
module fir_decim_top_test;
    import fir_pkg::*;
    localparam int TMO = 30000;
    localparam int NS  = 48;
    logic        ref_clk;
    logic        rst_n;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [11:0] sample_in;
    logic        sample_valid;
    logic        sample_ready;
    logic [11:0] out_data;
    logic        out_valid;
    logic        out_ready = 1'b0;
    logic        stall_hold = 1'b0;
    int          err_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          h[12];
    int          xs[$];
    logic [11:0] got[$];
    logic [11:0] prev[$];

    fir_decim_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_in(sample_in), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // output sink with a periodic stall
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        out_ready <= !stall_hold && (cyc % 5 != 0);
        if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_data);
        if (cyc == TMO)
        begin
            err_count++;
            summarize();
        end
    end

    task summarize();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // entered just after a rising edge, leaves one idle cycle behind
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic er);
        int   n;
        logic hit;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        hit = 1'b0;
        while (!hit && n < 50)
        begin
            @(posedge ref_clk);
            hit = (pready === 1'b1);
            n++;
        end
        // answer taken at the edge that sees pready high
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (!hit) chk(32'h0, 32'h1);
        @(posedge ref_clk);
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk({31'h0, e}, 32'h0);
        chk(r, x);
    endtask : rd_chk

    // holds sample_valid high; caller lowers it after the batch
    task push(input logic [11:0] v, input int lim, output logic ok);
        int n;
        sample_in <= v;
        sample_valid <= 1'b1;
        ok = 1'b0;
        n = 0;
        while (!ok && n < lim)
        begin
            @(posedge ref_clk);
            ok = (sample_ready === 1'b1);
            n++;
        end
    endtask : push

    function automatic logic [31:0] mk(int rate, int fdec, int choice, int odd, int chan, int cust, int src);
        return 32'((rate << F_RATE) | (fdec << F_FDEC) | (choice << F_CHOICE) | (odd << F_ODD)
            | (chan << F_CHAN_EN) | (cust << F_CUST_EN) | (src << F_SRC_SEL));
    endfunction : mk

    // mirrored tap line, h0 on newest and oldest sample
    function automatic logic [11:0] model(int i, bit odd);
        int acc;
        int t;
        acc = 0;
        t = odd ? 23 : 24;
        for (int k = 0; k < t; k++) acc += h[(k < 12) ? k : t - 1 - k] * xs[i - k];
        acc = acc >>> COEF_FRAC;
        if (acc > 2047) acc = 2047;
        if (acc < -2048) acc = -2048;
        return 12'(acc);
    endfunction : model

    task load_coefs(input int s);
        for (int k = 0; k < 12; k++)
        begin
            h[k] = s * ((k == 11) ? 1024 : 16 * k - 90);
            wr(ADDR_COEF0 + 8'(4 * k), 32'(h[k]) & 32'hfff);
        end
    endtask : load_coefs

    // kind 0 built-in, 1 custom, 2 filter off
    task run_mode(input logic [31:0] ctrl, input int nd, input bit odd, input int kind);
        logic        ok;
        logic        e;
        logic [31:0] r;
        int          ne;
        int          w;
        int          i;
        wr(ADDR_CTRL, ctrl);
        rd_chk(ADDR_CTRL, ctrl);
        if (kind != 2)
        begin
            apb(1'b0, ADDR_STATUS, 32'h0, r, e);
            chk(32'(r[6:4]), 32'(nd - 1));
            chk(32'(r[2]), 32'(nd == 1));
            if (kind == 0) chk(32'(r[1]), 32'h1);
        end
        got.delete();
        xs.delete();
        for (int k = 0; k < NS; k++)
        begin
            xs.push_back(((k * 53) % 401) - 200);
            push(12'(xs[k]), 50, ok);
            if (!ok) chk(32'h0, 32'h1);
        end
        sample_valid <= 1'b0;
        @(posedge ref_clk);
        ne = NS / nd;
        w = 0;
        while (got.size() < ne && w < 300)
        begin
            @(posedge ref_clk);
            w++;
        end
        repeat (10) @(posedge ref_clk);
        chk(32'(got.size()), 32'(ne));
        for (int j = 0; j < got.size() && j < ne; j++)
        begin
            i = nd * j + nd - 1;
            if (kind == 2) chk({20'h0, got[j]}, {20'h0, 12'(xs[i])});
            if (kind == 1 && i >= 23) chk({20'h0, got[j]}, {20'h0, model(i, odd)});
            if (kind == 0 && i >= 23 && prev.size() == ne) chk({20'h0, got[j]}, {20'h0, prev[j]});
        end
        prev = got;
    endtask : run_mode

    initial
    begin : main
        logic [31:0] r;
        logic [31:0] base;
        logic        e;
        logic        ok;
        int          acc;
        int          cr[5] = '{0, 0, 1, 2, 3};
        int          cf[5] = '{0, 0, 0, 1, 4};
        int          co[5] = '{0, 1, 1, 0, 1};
        int          cn[5] = '{1, 1, 2, 4, 8};
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sample_in = 12'h000;
        sample_valid = 1'b0;
        repeat (12) @(posedge ref_clk);
        chk({31'h0, out_valid}, 32'h0);
        chk({31'h0, pready}, 32'h0);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd_chk(ADDR_CTRL, {19'h0, CTRL_RESET});
        rd_chk(ADDR_COEF0, {20'h0, COEF_RESET});
        rd_chk(ADDR_OUTCNT, 32'h0);
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        apb(1'b1, 8'h44, 32'h5, r, e);
        chk({31'h0, e}, 32'h1);
        $display("test registers done");
        for (int c = 0; c < 6; c++)
        begin
            prev.delete();
            load_coefs(1);
            run_mode(mk((c < 2) ? 1 : 2, (c < 2) ? 0 : 1, c, (c < 2 || c == 5), 1, 0, 0), (c < 2) ? 2 : 4,
                (c < 2 || c == 5), 0);
            load_coefs(-1);
            run_mode(mk((c < 2) ? 1 : 2, (c < 2) ? 0 : 1, c, (c < 2 || c == 5), 1, 0, 0), (c < 2) ? 2 : 4,
                (c < 2 || c == 5), 0);
        end
        $display("test builtin done");
        wr(ADDR_CTRL, mk(1, 0, 2, 0, 1, 0, 0));
        apb(1'b0, ADDR_STATUS, 32'h0, r, e);
        chk(32'(r[1]), 32'h0);
        load_coefs(1);
        rd_chk(ADDR_COEF0, 32'(h[0]) & 32'hfff);
        rd_chk(ADDR_COEF11, 32'(h[11]) & 32'hfff);
        for (int c = 0; c < 5; c++) run_mode(mk(cr[c], cf[c], 0, co[c], 1, 1, 1), cn[c], co[c], 1);
        run_mode(mk(2, 1, 0, 0, 0, 0, 0), 1, 1'b0, 2);
        $display("test custom done");
        stall_hold <= 1'b1;
        repeat (3) @(posedge ref_clk);
        apb(1'b0, ADDR_OUTCNT, 32'h0, base, e);
        got.delete();
        acc = 0;
        for (int k = 0; k < 4; k++)
        begin
            push(12'h100 + 12'(k), 20, ok);
            if (ok) acc++;
        end
        sample_valid <= 1'b0;
        @(posedge ref_clk);
        chk(32'(acc), 32'h3);
        apb(1'b0, ADDR_OUTCNT, 32'h0, r, e);
        chk((r - base) & 32'hffff, 32'h2);
        stall_hold <= 1'b0;
        repeat (40) @(posedge ref_clk);
        chk(32'(got.size()), 32'h3);
        for (int k = 0; k < 3 && k < got.size(); k++) chk({20'h0, got[k]}, 32'h100 + 32'(k));
        $display("test buffer done");
        summarize();
    end : main
endmodule : fir_decim_top_test
